// File: rtl/conv_regs.sv
/*
  AXI4-Lite register block for the converter: sequence slots, window
  limits three, result register, events and a simple conversion walker.
  Assumes the analog core answers each request with a done pulse.
*/
module conv_regs
  import conv_regs_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output core_req_t core_req,
  input wire core_resp_t core_resp,
  output logic irq
);

  typedef enum {ST_IDLE, ST_REQ, ST_WAIT, ST_CAL} walk_state_t;

  // ****************************************
  // State
  // ****************************************
  logic [31:0] sequence_order_select, next_sequence_order_select;
  logic [31:0] window_limits_three, next_window_limits_three;
  logic [31:0] conversion_result, next_conversion_result;
  logic [31:0] config_register_one, next_config_register_one;
  logic [GUARD_W-1:0] guard_three, next_guard_three;
  logic [EV_W-1:0] ev_status, next_ev_status;
  logic [EV_W-1:0] ev_mask, next_ev_mask;
  logic conversion_start_flag, next_conversion_start_flag;
  logic channel_config_ready, next_channel_config_ready;
  logic [3:0] settle, next_settle;
  logic window_flag, next_window_flag;
  walk_state_t state, next_state;
  logic [2:0] slot_idx, next_slot_idx;
  logic [4:0] bit_idx, next_bit_idx;
  core_req_t next_core_req;
  logic [31:0] awaddr_q, next_awaddr_q;
  logic aw_held, next_aw_held;
  logic [31:0] wdata_q, next_wdata_q;
  logic [3:0] wstrb_q, next_wstrb_q;
  logic w_held, next_w_held;
  logic bvalid, next_bvalid;
  logic [1:0] bresp, next_bresp;
  logic rvalid, next_rvalid;
  logic [1:0] rresp, next_rresp;
  logic [31:0] rdata, next_rdata;

  // ****************************************
  // Slot decode
  // ****************************************
  logic [SLOT_COUNT-1:0] slot_live;
  logic [3:0] slot_code [SLOT_COUNT];
  genvar gi;
  generate
    for (gi = 0; gi < SLOT_COUNT; gi++) begin : g_slot
      // Slot lives only if every lower slot and itself are not end codes
      assign slot_code[gi] = sequence_order_select[gi*SLOT_W +: SLOT_W];
      if (gi == 0) begin : g_first
        assign slot_live[gi] = slot_code[gi] != SLOT_END_CODE;
      end else begin : g_rest
        assign slot_live[gi] = slot_live[gi-1] &&
                               slot_code[gi] != SLOT_END_CODE;
      end
    end
  endgenerate

  logic seq_mode;
  assign seq_mode = config_register_one[CFG_SEQ_MODE_BIT];

  // ****************************************
  // Result shaping
  // ****************************************
  logic [15:0] shaped;
  result_shaper u_shaper (
    .sample(core_resp.sample),
    .resolution(config_register_one[CFG_RES_LSB +: 2]),
    .left_align(config_register_one[CFG_ALIGN_BIT]),
    .shaped(shaped)
  );

  // Window compare on the raw sample
  logic out_of_window;
  assign out_of_window =
    core_resp.sample > window_limits_three[HIGH_LSB +: LIMIT_W] ||
    core_resp.sample < window_limits_three[LIMIT_W-1:0];

  logic wr_fire, rd_fire;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [31:0] strb_mask;
  always_comb begin
    wr_fire = (aw_held || s_axi_awvalid) && (w_held || s_axi_wvalid) &&
              !bvalid;
    wr_addr = aw_held ? awaddr_q[7:0] : s_axi_awaddr;
    wr_data = w_held ? wdata_q : s_axi_wdata;
    wr_strb = w_held ? wstrb_q : s_axi_wstrb;
    strb_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}},
                 {8{wr_strb[1]}}, {8{wr_strb[0]}}};
    rd_fire = s_axi_arvalid && !rvalid;
  end

  assign s_axi_awready = !aw_held && !bvalid;
  assign s_axi_wready = !w_held && !bvalid;
  assign s_axi_arready = !rvalid;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rresp = rresp;
  assign s_axi_rdata = rdata;
  assign irq = |(ev_status & ev_mask);

  // ****************************************
  // Next-state logic
  // ****************************************
  logic [EV_W-1:0] ev_set;
  logic sel_write;
  logic [4:0] scan;
  logic found;
  always_comb begin
    next_sequence_order_select = sequence_order_select;
    next_window_limits_three = window_limits_three;
    next_conversion_result = conversion_result;
    next_config_register_one = config_register_one;
    next_guard_three = guard_three;
    next_ev_mask = ev_mask;
    next_conversion_start_flag = conversion_start_flag;
    next_channel_config_ready = channel_config_ready;
    next_settle = settle;
    next_window_flag = window_flag;
    next_state = state;
    next_slot_idx = slot_idx;
    next_bit_idx = bit_idx;
    next_core_req = core_req;
    next_core_req.start = 1'b0;
    next_awaddr_q = awaddr_q;
    next_aw_held = aw_held;
    next_wdata_q = wdata_q;
    next_wstrb_q = wstrb_q;
    next_w_held = w_held;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rresp = rresp;
    next_rdata = rdata;
    ev_set = '0;
    sel_write = 1'b0;
    scan = 5'd0;
    found = 1'b0;

    // Bus write channel capture
    if (s_axi_awvalid && s_axi_awready && !wr_fire) begin
      next_aw_held = 1'b1;
      next_awaddr_q = {24'h0, s_axi_awaddr};
    end
    if (s_axi_wvalid && s_axi_wready && !wr_fire) begin
      next_w_held = 1'b1;
      next_wdata_q = s_axi_wdata;
      next_wstrb_q = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (wr_fire) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = AXI_OKAY;
      case (wr_addr)
        OFS_SEQUENCE_ORDER_SELECT: begin
          // Held off while converting or config settling
          if (!conversion_start_flag && channel_config_ready) begin
            next_sequence_order_select = (sequence_order_select &
              ~strb_mask) | (wr_data & strb_mask);
            sel_write = 1'b1;
          end
        end
        OFS_WINDOW_LIMITS_THREE: begin
          next_window_limits_three = ((window_limits_three & ~strb_mask) |
            (wr_data & strb_mask)) & 32'h0fff_0fff;
        end
        OFS_CONFIG_REGISTER_ONE: begin
          next_config_register_one = (config_register_one & ~strb_mask) |
            (wr_data & strb_mask);
          if (next_config_register_one[CFG_SEQ_MODE_BIT] != seq_mode) begin
            sel_write = 1'b1;
          end
        end
        OFS_GUARD_THREE: begin
          next_guard_three = wr_data[GUARD_W-1:0];
        end
        OFS_EVENT_MASK: begin
          next_ev_mask = wr_data[EV_W-1:0];
        end
        OFS_EVENT_STATUS, OFS_CONVERSION_RESULT: begin
        end
        OFS_CONTROL: begin
          if (wr_data[CTL_START_BIT] && state == ST_IDLE) begin
            next_conversion_start_flag = 1'b1;
            next_state = ST_REQ;
            next_slot_idx = 3'd0;
            next_bit_idx = 5'd0;
          end else if (wr_data[CTL_CAL_BIT] && state == ST_IDLE) begin
            next_core_req.calibrate = 1'b1;
            next_state = ST_CAL;
          end
        end
        default: begin
          next_bresp = AXI_SLVERR;
        end
      endcase
    end

    // Config settling after a channel configuration change
    if (sel_write) begin
      next_channel_config_ready = 1'b0;
      next_settle = CFG_SETTLE_CYCLES;
    end else if (!channel_config_ready) begin
      if (settle == 4'h0) begin
        next_channel_config_ready = 1'b1;
        ev_set[EV_CFG_READY] = 1'b1;
      end else begin
        next_settle = settle - 4'h1;
      end
    end

    // Conversion walker
    case (state)
      ST_IDLE: begin
      end
      ST_REQ: begin
        if (seq_mode) begin
          if (slot_live[slot_idx]) begin
            next_core_req.channel = slot_code[slot_idx];
            next_core_req.start = 1'b1;
            next_state = ST_WAIT;
          end else begin
            next_state = ST_IDLE;
            next_conversion_start_flag = 1'b0;
            ev_set[EV_EOS] = 1'b1;
          end
        end else begin
          for (int i = 0; i < BITMAP_W; i++) begin
            if (!found && i >= bit_idx &&
                sequence_order_select[i]) begin
              found = 1'b1;
              scan = 5'(i);
            end
          end
          if (found) begin
            next_core_req.channel = scan[3:0];
            next_bit_idx = scan;
            next_core_req.start = 1'b1;
            next_state = ST_WAIT;
          end else begin
            next_state = ST_IDLE;
            next_conversion_start_flag = 1'b0;
            ev_set[EV_EOS] = 1'b1;
          end
        end
      end
      ST_WAIT: begin
        if (core_resp.done) begin
          next_conversion_result = {16'h0, shaped};
          ev_set[EV_EOC] = 1'b1;
          if (guard_three[core_req.channel] && out_of_window) begin
            ev_set[EV_WINDOW] = 1'b1;
            next_window_flag = 1'b1;
          end
          if (seq_mode && slot_idx == 3'(SLOT_COUNT - 1)) begin
            next_state = ST_IDLE;
            next_conversion_start_flag = 1'b0;
            ev_set[EV_EOS] = 1'b1;
          end else begin
            next_slot_idx = slot_idx + 3'd1;
            next_bit_idx = bit_idx + 5'd1;
            next_state = ST_REQ;
          end
        end
      end
      ST_CAL: begin
        if (core_resp.cal_done) begin
          next_core_req.calibrate = 1'b0;
          next_conversion_result = {25'h0, core_resp.calfact};
          ev_set[EV_CAL_DONE] = 1'b1;
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase

    // Sticky events, set wins over write-one clear
    next_ev_status = ev_status;
    if (wr_fire && wr_addr == OFS_EVENT_STATUS) begin
      next_ev_status = ev_status & ~wr_data[EV_W-1:0];
    end
    next_ev_status = next_ev_status | ev_set;

    // Read channel
    if (s_axi_rready && rvalid) begin
      next_rvalid = 1'b0;
    end
    if (rd_fire) begin
      next_rvalid = 1'b1;
      next_rresp = AXI_OKAY;
      case (s_axi_araddr)
        OFS_SEQUENCE_ORDER_SELECT: next_rdata = sequence_order_select;
        OFS_WINDOW_LIMITS_THREE: next_rdata = window_limits_three;
        OFS_CONVERSION_RESULT: next_rdata = conversion_result;
        OFS_CONFIG_REGISTER_ONE: next_rdata = config_register_one;
        OFS_GUARD_THREE: next_rdata = {17'h0, guard_three};
        OFS_EVENT_STATUS: next_rdata = {27'h0, ev_status};
        OFS_EVENT_MASK: next_rdata = {27'h0, ev_mask};
        OFS_CONTROL: next_rdata = {28'h0, window_flag,
          conversion_start_flag, channel_config_ready, 1'b0};
        default: begin
          next_rdata = 32'h0000_0000;
          next_rresp = AXI_SLVERR;
        end
      endcase
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sequence_order_select <= RST_SEQUENCE_ORDER_SELECT;
      window_limits_three <= RST_WINDOW_LIMITS_THREE;
      conversion_result <= RST_CONVERSION_RESULT;
      config_register_one <= 32'h0000_0000;
      guard_three <= '0;
      ev_status <= '0;
      ev_mask <= '0;
      conversion_start_flag <= 1'b0;
      channel_config_ready <= 1'b1;
      settle <= 4'h0;
      window_flag <= 1'b0;
      state <= ST_IDLE;
      slot_idx <= 3'd0;
      bit_idx <= 5'd0;
      core_req <= '0;
      awaddr_q <= 32'h0000_0000;
      aw_held <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      w_held <= 1'b0;
      bvalid <= 1'b0;
      bresp <= AXI_OKAY;
      rvalid <= 1'b0;
      rresp <= AXI_OKAY;
      rdata <= 32'h0000_0000;
    end else begin
      sequence_order_select <= next_sequence_order_select;
      window_limits_three <= next_window_limits_three;
      conversion_result <= next_conversion_result;
      config_register_one <= next_config_register_one;
      guard_three <= next_guard_three;
      ev_status <= next_ev_status;
      ev_mask <= next_ev_mask;
      conversion_start_flag <= next_conversion_start_flag;
      channel_config_ready <= next_channel_config_ready;
      settle <= next_settle;
      window_flag <= next_window_flag;
      state <= next_state;
      slot_idx <= next_slot_idx;
      bit_idx <= next_bit_idx;
      core_req <= next_core_req;
      awaddr_q <= next_awaddr_q;
      aw_held <= next_aw_held;
      wdata_q <= next_wdata_q;
      wstrb_q <= next_wstrb_q;
      w_held <= next_w_held;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
    end
  end

endmodule

// File: rtl/conv_regs_pkg.sv
/*
  Constants, register map and carrier types for the converter register
  block. Assumes a 32-bit AXI4-Lite register bus clocked by aclk.
*/
// Function
// - Sequence mode keeps eight 4-bit slots, slot one lowest, run one to eight.
// - Slot codes 0000 to 1110 pick analog channels 0 to 14.
// - Slot code 1111 picks no channel and ends the sequence there.
// - Slots above the first end code are ignored.
// - Mode bit 0 reads the register as a channel bitmap, 1 as a slot list.
// - Window limits three hold high in 27:16, low in 11:0, reset 0x0FFF0000.
// - The result register is read-only in 15:0, holding the latest result.
// - Results are placed left or right aligned by alignment and resolution.
// - Right after calibration the result low seven bits hold the factor.
// - In bitmap mode each set bit of 0 to 18 selects its channel for conversion; bits 16 to 18 select channels 0 to 2.
// - Selection writes are ignored until channel config ready returns.
package conv_regs_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] OFS_SEQUENCE_ORDER_SELECT = 8'h28;
  localparam logic [7:0] OFS_WINDOW_LIMITS_THREE = 8'h2c;
  localparam logic [7:0] OFS_CONVERSION_RESULT = 8'h40;
  localparam logic [7:0] OFS_CONFIG_REGISTER_ONE = 8'h0c;
  localparam logic [7:0] OFS_EVENT_STATUS = 8'h00;
  localparam logic [7:0] OFS_EVENT_MASK = 8'h04;
  localparam logic [7:0] OFS_CONTROL = 8'h08;
  localparam logic [7:0] OFS_GUARD_THREE = 8'h10;

  // ****************************************
  // Reset values and fields
  // ****************************************
  localparam logic [31:0] RST_SEQUENCE_ORDER_SELECT = 32'h0000_0000;
  localparam logic [31:0] RST_WINDOW_LIMITS_THREE = 32'h0fff_0000;
  localparam logic [31:0] RST_CONVERSION_RESULT = 32'h0000_0000;
  localparam int SLOT_COUNT = 8;
  localparam int SLOT_W = 4;
  localparam logic [3:0] SLOT_END_CODE = 4'hf;
  localparam int BITMAP_W = 19;
  localparam int HIGH_LSB = 16;
  localparam int LIMIT_W = 12;
  localparam int CALFACT_W = 7;
  localparam int GUARD_W = 15;
  // Config register one bits
  localparam int CFG_SEQ_MODE_BIT = 21;
  localparam int CFG_ALIGN_BIT = 5;
  localparam int CFG_RES_LSB = 3;
  // Control register bits
  localparam int CTL_START_BIT = 2;
  localparam int CTL_CAL_BIT = 31;
  // Event bits
  localparam int EV_EOC = 0;
  localparam int EV_EOS = 1;
  localparam int EV_WINDOW = 2;
  localparam int EV_CAL_DONE = 3;
  localparam int EV_CFG_READY = 4;
  localparam int EV_W = 5;
  // Cycles for channel config to settle
  localparam logic [3:0] CFG_SETTLE_CYCLES = 4'h3;
  localparam logic [1:0] AXI_OKAY = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;

  // ****************************************
  // Carrier types
  // ****************************************
  typedef struct packed {
    logic [3:0] channel;
    logic start;
    logic calibrate;
  } core_req_t;

  typedef struct packed {
    logic done;
    logic cal_done;
    logic [11:0] sample;
    logic [6:0] calfact;
  } core_resp_t;

endpackage

// File: rtl/result_shaper.sv
/*
  Places a raw 12-bit sample into the 16-bit result field by resolution
  and alignment. Assumes resolution code 0..3 means 12,10,8,6 bits.
*/
module result_shaper
  import conv_regs_pkg::*;
(
  input wire logic [11:0] sample,
  input wire logic [1:0] resolution,
  input wire logic left_align,
  output logic [15:0] shaped
);

  // ****************************************
  // Truncate then align
  // ****************************************
  logic [11:0] trimmed;
  logic [3:0] drop;
  always_comb begin
    drop = {1'b0, resolution, 1'b0};
    trimmed = sample >> drop;
    if (left_align) begin
      shaped = {4'h0, trimmed} << (4'd4 + drop);
    end else begin
      shaped = {4'h0, trimmed};
    end
  end

endmodule

// File: verif/conv_regs_properties.sv
/*
  Checker for conv_regs, bound to the ports of that module.
  Assumes one clock aclk and the synchronous active-low aresetn.
*/
module conv_regs_properties
  import conv_regs_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire core_req_t core_req,
  input wire core_resp_t core_resp,
  input wire logic irq
);
  // ****************
  // Properties
  // ****************
  // Single clock domain for all checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Steps of a conversion request and a taken bus write
  sequence s_issue;
    core_req.start;
  endsequence
  sequence s_pause;
    !core_req.start [*2];
  endsequence
  sequence s_write_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence

  chk_reset_quiet: assert property ($rose(aresetn) |-> !s_axi_bvalid &&
    !s_axi_rvalid && !(|core_req) && !irq) else $error("not idle at reset");
  chk_write_answer: assert property (s_write_taken |=> s_axi_bvalid)
    else $error("write answer late");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read answer late");
  chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid) else $error("write answer dropped");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer moved");
  chk_start_single: assert property (
    s_issue |=> s_pause) else $error("start not a lone pulse");
  chk_no_end_code: assert property (
    s_issue |-> core_req.channel != SLOT_END_CODE)
    else $error("end code converted");
  chk_channel_hold: assert property (
    !core_req.start && $past(aresetn) |-> $stable(core_req.channel))
    else $error("channel moved without start");
  chk_cal_hold: assert property (
    core_req.calibrate && !core_resp.cal_done |=> core_req.calibrate)
    else $error("calibrate dropped early");
endmodule

bind conv_regs conv_regs_properties props (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .core_req(core_req), .core_resp(core_resp), .irq(irq)
);

// File: verif/core_model.sv
/*
  Behavioural analog core: converts one channel per start pulse and
  runs a calibration while calibrate is high. Assumes the bench clock.
*/
module core_model
  import conv_regs_pkg::*;
#(
  parameter logic [6:0] CAL_FACTOR = 7'h5b
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire core_req_t core_req,
  input wire logic [3:0] lag,
  output core_resp_t core_resp
);
  logic busy, is_cal, armed;
  logic [3:0] chan, left;

  // Answer lag+1 cycles after the start is sampled; idle lines toggle so stale data shows
  always @(posedge aclk) begin
    core_resp.done <= 1'b0;
    core_resp.cal_done <= 1'b0;
    core_resp.sample <= ~core_resp.sample;
    core_resp.calfact <= ~core_resp.calfact;
    if (!core_req.calibrate)
      armed <= 1'b0;
    if (!aresetn) begin
      busy <= 1'b0;
      armed <= 1'b0;
      core_resp.sample <= 12'h000;
      core_resp.calfact <= 7'h00;
    end else if (core_req.start) begin
      busy <= 1'b1;
      is_cal <= 1'b0;
      chan <= core_req.channel;
      left <= lag;
    end else if (core_req.calibrate && !armed && !busy) begin
      busy <= 1'b1;
      is_cal <= 1'b1;
      armed <= 1'b1;
      left <= lag;
    end else if (busy && left != 4'h0) begin
      left <= left - 4'h1;
    end else if (busy) begin
      busy <= 1'b0;
      core_resp.done <= !is_cal;
      core_resp.cal_done <= is_cal;
      core_resp.sample <= {chan, 8'ha5};
      core_resp.calfact <= CAL_FACTOR;
    end
  end
endmodule

// File: verif/tb_top.sv
/*
  Self-checking bench for conv_regs with an AXI4-Lite master.
  Assumes the package, checker and core model are compiled first.
*/
module tb_top
  import conv_regs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [6:0] CAL_FACTOR = 7'h5b;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1;
  logic arvalid = 1'b0, rready = 1'b1;
  logic [3:0] lag = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rdv;
  core_req_t core_req;
  core_resp_t core_resp;
  logic [3:0] chq[$];
  int err_count = 0;
  int num_checks = 0;

  conv_regs dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .core_req(core_req),
    .core_resp(core_resp), .irq(irq)
  );
  core_model #(.CAL_FACTOR(CAL_FACTOR)) partner (
    .aclk(aclk), .aresetn(aresetn), .core_req(core_req),
    .lag(lag), .core_resp(core_resp)
  );

  // Clock and log of converted channels
  always #25 aclk = ~aclk;
  always @(posedge aclk) begin
    if (aresetn && core_req.start)
      chq.push_back(core_req.channel);
  end

  // ****************
  // Bus tasks
  // ****************
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Readies sampled at the falling edge, stable until the rising one;
  // bready and rready stay high so back-to-back calls never toggle them
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tr;
    tr = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!tr) begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tr = bvalid;
      resp = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
  endtask

  task automatic rd(input logic [7:0] a);
    logic ta, tr;
    tr = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    while (!tr) begin
      @(negedge aclk);
      ta = arvalid && arready;
      tr = rvalid;
      rdv = rdata;
      resp = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
    end
  endtask

  task automatic poll(input logic [7:0] a, input int b, input logic v);
    int n;
    n = 0;
    rd(a);
    while (rdv[b] !== v && n < 100) begin
      rd(a);
      n++;
    end
    chk("poll bit", {31'h0, rdv[b]}, {31'h0, v});
  endtask

  // Program slots, start, wait for idle, compare channel order
  task automatic run(input logic [31:0] sel, chans, input int n);
    poll(OFS_CONTROL, 1, 1'b1);
    wr(OFS_SEQUENCE_ORDER_SELECT, sel);
    poll(OFS_CONTROL, 1, 1'b1);
    chq.delete();
    wr(OFS_CONTROL, 32'h1 << CTL_START_BIT);
    poll(OFS_CONTROL, CTL_START_BIT, 1'b0);
    chk("count", 32'(chq.size()), 32'(n));
    for (int i = 0; i < n; i++)
      chk("channel", {28'h0, chq[i]}, {28'h0, chans[4*i +: 4]});
  endtask

  // ****************
  // Scenarios
  // ****************
  task automatic t_access;
    rd(OFS_SEQUENCE_ORDER_SELECT);
    chk("order reset", rdv, 32'h0000_0000);
    rd(OFS_WINDOW_LIMITS_THREE);
    chk("limits reset", rdv, 32'h0fff_0000);
    wr(OFS_WINDOW_LIMITS_THREE, 32'h0abc_0123);
    rd(OFS_WINDOW_LIMITS_THREE);
    chk("limits", rdv, 32'h0abc_0123);
    wr(OFS_CONVERSION_RESULT, 32'h0000_ffff);
    rd(OFS_CONVERSION_RESULT);
    chk("result", rdv, 32'h0000_0000);
    wr(8'h80, 32'h0000_0001);
    chk("bresp", {30'h0, resp}, 32'h0000_0002);
    rd(8'h80);
    chk("rresp", {30'h0, resp}, 32'h0000_0002);
  endtask

  task automatic t_sequence;
    wr(OFS_CONFIG_REGISTER_ONE, 32'h1 << CFG_SEQ_MODE_BIT);
    run(32'h7654_3210, 32'h7654_3210, 8);
    run(32'hfedc_ba98, 32'h0edc_ba98, 7);
    run(32'h0007_f30e, 32'h0000_030e, 3);
    rd(OFS_CONVERSION_RESULT);
    chk("result", rdv, 32'h0000_03a5);
  endtask

  task automatic t_guard;
    lag <= 4'h6;
    wr(OFS_SEQUENCE_ORDER_SELECT, 32'hffff_ff91);
    poll(OFS_CONTROL, 1, 1'b1);
    wr(OFS_CONTROL, 32'h1 << CTL_START_BIT);
    wr(OFS_SEQUENCE_ORDER_SELECT, 32'h0000_0000);
    poll(OFS_CONTROL, CTL_START_BIT, 1'b0);
    rd(OFS_SEQUENCE_ORDER_SELECT);
    chk("busy write", rdv, 32'hffff_ff91);
    wr(OFS_SEQUENCE_ORDER_SELECT, 32'hffff_ff22);
    wr(OFS_SEQUENCE_ORDER_SELECT, 32'hffff_ff33);
    poll(OFS_CONTROL, 1, 1'b1);
    rd(OFS_SEQUENCE_ORDER_SELECT);
    chk("early write", rdv, 32'hffff_ff22);
  endtask

  task automatic t_modes;
    wr(OFS_CONFIG_REGISTER_ONE, 32'h0000_0000);
    run(32'h0000_0222, 32'h0000_0951, 3);
    lag <= 4'h0;
    wr(OFS_CONFIG_REGISTER_ONE, 32'h1 << CFG_SEQ_MODE_BIT |
      32'h1 << CFG_ALIGN_BIT);
    run(32'hffff_fff2, 32'h0000_0002, 1);
    rd(OFS_CONVERSION_RESULT);
    chk("left align", rdv, 32'h0000_2a50);
  endtask

  task automatic t_window;
    wr(OFS_CONFIG_REGISTER_ONE, 32'h1 << CFG_SEQ_MODE_BIT |
      32'h1 << CFG_RES_LSB);
    wr(OFS_WINDOW_LIMITS_THREE, 32'h0800_0100);
    wr(OFS_GUARD_THREE, 32'h0000_0209);
    wr(OFS_EVENT_STATUS, 32'h0000_001f);
    run(32'hffff_fff3, 32'h0000_0003, 1);
    rd(OFS_CONVERSION_RESULT);
    chk("ten bit", rdv, 32'h0000_00e9);
    rd(OFS_EVENT_STATUS);
    chk("inside", {31'h0, rdv[EV_WINDOW]}, 32'h0000_0000);
    run(32'hffff_fff0, 32'h0000_0000, 1);
    rd(OFS_EVENT_STATUS);
    chk("below", {31'h0, rdv[EV_WINDOW]}, 32'h0000_0001);
    chk("irq masked", {31'h0, irq}, 32'h0000_0000);
    wr(OFS_EVENT_MASK, 32'h1 << EV_WINDOW);
    chk("irq", {31'h0, irq}, 32'h0000_0001);
    wr(OFS_EVENT_STATUS, 32'h1 << EV_WINDOW);
    chk("irq cleared", {31'h0, irq}, 32'h0000_0000);
    run(32'hffff_fff9, 32'h0000_0009, 1);
    chk("above", {31'h0, irq}, 32'h0000_0001);
  endtask

  task automatic t_cal;
    lag <= 4'h3;
    wr(OFS_CONTROL, 32'h1 << CTL_CAL_BIT);
    poll(OFS_EVENT_STATUS, EV_CAL_DONE, 1'b1);
    rd(OFS_CONVERSION_RESULT);
    chk("factor", {25'h0, rdv[6:0]}, {25'h0, CAL_FACTOR});
  endtask

  task automatic tally_and_finish;
    if (err_count == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Main sequence and watchdog
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_access();
    t_sequence();
    t_guard();
    t_modes();
    t_window();
    t_cal();
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    tally_and_finish();
  end
endmodule
